/* src/wwd_watchdog.sv */
// windowed watchdog timer with apb register access
// Summary of operation
// RULE1 - 24-bit down-counter clocked through a divide-by-four prescaler from selected clock
// RULE2 - timeout from 256x4 to 2^24x4 clock periods, steps of four periods
// RULE3 - counter reaching zero without reload requests chip reset
// RULE4 - windowed mode accepts reload only below window value; earlier reload is violation
// RULE5 - optional warning interrupt when counter reaches programmable warning count
// RULE6 - enable set by software only; cleared by reset or watchdog event
// RULE7 - wrong or incomplete feed sequence immediately triggers reset or interrupt
// RULE8 - flag records that the watchdog caused a reset; the code clears it on rst, so it reads set only until the system reset
// RULE9 - basic variant selects rc oscillator, watchdog oscillator or main clock
// RULE10 - windowed variant selects only rc oscillator or watchdog oscillator
// RULE11 - watchdog oscillator may be kept running in deep sleep
// RULE12 - software feeds with two consecutive fixed writes, nothing between
// RULE13 - reload, configuration and status pass safely into counting domain
//
// Local design decisions: register access over APB and the register addresses.
`include "wwd_defines.svh"
`default_nettype none
module wwd_watchdog #(
    parameter bit WINDOWED = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // watchdog clock source enables, one pulse per source period
    input  wire logic        ircTick,
    input  wire logic        wdoTick,
    // system outputs
    output logic             chipResetReq,
    output logic             wdIrq,
    output logic             warnIrq,
    output logic             wdoRunInSleep
);

    // registers
    // everything runs on clk_sys; the selected oscillator only
    // appears as an enable pulse, so no signal crosses a clock domain
    logic                   enable_r;
    logic                   rstEn_r;
    logic                   warnEn_r;
    logic                   winEn_r;
    logic                   keepOsc_r;
    logic [1:0]             clkSel_r;
    logic [`WWD_CNT_W-1:0]  timeout_r;
    logic [`WWD_CNT_W-1:0]  warnVal_r;
    logic [`WWD_CNT_W-1:0]  window_r;
    logic [`WWD_CNT_W-1:0]  count_r;
    logic [1:0]             presc_r;
    logic                   toFlag_r;
    logic                   warnFlag_r;
    logic                   causeFlag_r;
    logic                   chipReset_r;
    logic                   reloadPend_r;
    logic [31:0]            prdata_r;
    wwd_pkg::wwd_feed_t     feedSt_r;

    // address match helper, shared by every register select below
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // apb decode
    // an access is the second cycle of a transfer, psel and penable high;
    // writes take effect at that edge and nowhere else
    wire apbAcc   = psel && penable;
    wire apbWr    = apbAcc && pwrite;
    wire selCtrl  = hit(paddr, `WWD_OFF_CTRL);
    wire selTo    = hit(paddr, `WWD_OFF_TIMEOUT);
    wire selFeed  = hit(paddr, `WWD_OFF_FEED);
    wire selCount = hit(paddr, `WWD_OFF_COUNT);
    wire selWarn  = hit(paddr, `WWD_OFF_WARN);
    wire selWin   = hit(paddr, `WWD_OFF_WINDOW);
    wire selStat  = hit(paddr, `WWD_OFF_STATUS);
    wire mapped   = selCtrl | selTo | selFeed | selCount | selWarn | selWin | selStat;
    wire wrCtrl   = apbWr && selCtrl;
    wire wrStat   = apbWr && selStat;
    wire [7:0] feedByte = pwdata[7:0];
    // decode notes:
    // - pready is tied high, so every access phase completes in one cycle
    // - an unmapped offset answers with pslverr and reads as zero
    // - writes to the count offset are accepted on the bus and leave the count unchanged, but still break an armed feed
    // - the feed key uses only the low eight bits of the write data;
    //   the upper bits are ignored so software may write a full word
    // - paddr is compared in full, so misaligned offsets count as unmapped

    // ticks arrive synchronous to clk_sys as one-cycle enables,
    // so source selection is a plain mux with no glitch hazard;
    // changing the source mid-count only changes the rate of later ticks:
    // the prescaler phase is kept, trading exact first-period length
    // for a switch that never loses or doubles a tick

    // clock source select: main clock is every cycle, only offered by the basic variant
    wire mainAllowed = !WINDOWED;                                                        // RULE9 RULE10
    wire selTick = (clkSel_r == `WWD_SEL_WDO) ? wdoTick :
                   (clkSel_r == `WWD_SEL_MAIN && mainAllowed) ? 1'b1 : ircTick;          // RULE9 RULE10
    wire prescTick = enable_r && selTick && (presc_r == `WWD_PRESC_LAST);                // RULE1

    // the feed sequence is tracked even while the watchdog is disabled,
    // but only reported as a violation once enable is set;
    // a violation and a reload never coincide: the second write
    // either completes the sequence or breaks it
    // window check: a reload while count is still above the window
    // value comes too early and is treated like a broken sequence
    // feed sequence; any other mapped access or wrong value while armed breaks it
    wire firstOk  = apbWr && selFeed && feedByte == `WWD_FEED_FIRST;
    wire secondOk = apbWr && selFeed && feedByte == `WWD_FEED_SECOND;
    wire armed    = (feedSt_r == wwd_pkg::FEED_ARMED);
    wire feedDone = armed && secondOk;                                                   // RULE12
    wire feedBad  = enable_r && apbAcc && mapped && (armed ? !secondOk :
                    (selFeed && apbWr && !firstOk));                                     // RULE7
    wire tooEarly = feedDone && enable_r && winEn_r && (count_r > window_r);             // RULE4
    wire expire   = prescTick && !reloadPend_r && (count_r == {`WWD_CNT_W{1'b0}});       // RULE3
    wire wdEvent  = expire || feedBad || tooEarly;
    wire warnHit  = prescTick && warnEn_r && (count_r == warnVal_r);                     // RULE5
    wire [`WWD_CNT_W-1:0] tcWr = (pwdata[`WWD_CNT_W-1:0] < `WWD_TC_MIN) ?
                                 `WWD_TC_MIN : pwdata[`WWD_CNT_W-1:0];                   // RULE2

    // two-state feed tracker: idle waits for the first key byte,
    // armed expects the second key byte as the very next mapped access;
    // any mapped access, read or write, leaves the armed state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            feedSt_r <= wwd_pkg::FEED_IDLE;
        end else begin
            case (feedSt_r)
                wwd_pkg::FEED_IDLE: begin
                    if (firstOk) begin
                        feedSt_r <= wwd_pkg::FEED_ARMED;
                    end
                end
                wwd_pkg::FEED_ARMED: begin
                    if (apbAcc && mapped) begin
                        feedSt_r <= wwd_pkg::FEED_IDLE;
                    end
                end
                default: begin
                    feedSt_r <= wwd_pkg::FEED_IDLE;
                end
            endcase
        end
    end

    // control: enable is set-only from software
    // a watchdog event clears enable in the same cycle it is reported,
    // which stops the prescaler and reloads the counter, so one
    // expiry can never produce a second event before software acts;
    // the action bits stay as written so the cause stays readable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_r  <= 1'b0;
            rstEn_r   <= 1'b0;
            warnEn_r  <= 1'b0;
            winEn_r   <= 1'b0;
            keepOsc_r <= 1'b0;
            clkSel_r  <= `WWD_SEL_IRC;
        end else begin
            if (wdEvent) begin
                enable_r <= 1'b0;                                                        // RULE6
            end else if (wrCtrl && pwdata[`WWD_CTRL_EN]) begin
                enable_r <= 1'b1;                                                        // RULE6
            end
            // a select of three, or main clock in the windowed variant,
            // falls back to the rc oscillator
            // keep-osc only informs the power controller; counting ignores it
            if (wrCtrl) begin
                rstEn_r   <= pwdata[`WWD_CTRL_RSTEN];
                warnEn_r  <= pwdata[`WWD_CTRL_WARNEN];
                winEn_r   <= pwdata[`WWD_CTRL_WINEN];
                keepOsc_r <= pwdata[`WWD_CTRL_KEEPOSC];                                  // RULE11
                clkSel_r  <= pwdata[`WWD_CTRL_SEL_HI:`WWD_CTRL_SEL_LO];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timeout_r <= `WWD_TC_RESET;
            warnVal_r <= `WWD_WARN_RESET;
            window_r  <= `WWD_WIN_RESET;
        end else if (apbWr) begin
            if (selTo) begin
                timeout_r <= tcWr;                                                       // RULE2
            end
            if (selWarn) begin
                warnVal_r <= pwdata[`WWD_CNT_W-1:0];                                     // RULE5
            end
            if (selWin) begin
                window_r <= pwdata[`WWD_CNT_W-1:0];                                      // RULE4
            end
        end
    end

    // the timeout value takes effect on the next reload, while warning and
    // window values apply at once; changing timeout does not disturb a running count
    // a timeout write below the minimum is clamped rather than refused,
    // so the shortest period is always 256 prescaled ticks
    // the warning compare runs only on prescaled ticks, so the
    // flag rises once per pass through the programmed count

    // reload is held pending until the next counting tick so the
    // counter only ever changes on that tick; the prescaler is not touched by a reload
    // the prescaler restarts from zero whenever enable is low,
    // so the first period after enabling is exact;
    // count is held at the timeout value while disabled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_r      <= `WWD_TC_RESET;
            presc_r      <= 2'h0;
            reloadPend_r <= 1'b0;
        end else begin
            if (!enable_r) begin
                presc_r <= 2'h0;
            end else if (selTick) begin
                presc_r <= presc_r + 2'h1;                                               // RULE1
            end
            if (feedDone && !tooEarly) begin
                reloadPend_r <= 1'b1;                                                    // RULE13
            end else if (prescTick || !enable_r) begin
                reloadPend_r <= 1'b0;
            end
            if (!enable_r || (prescTick && reloadPend_r) || expire) begin
                count_r <= timeout_r;                                                    // RULE13
            end else if (prescTick) begin
                count_r <= count_r - {{(`WWD_CNT_W-1){1'b0}}, 1'b1};                     // RULE1
            end
        end
    end

    // expiry is checked at the tick that would take the count below zero,
    // so the period is the programmed value plus one, times four ticks;
    // a reload pending at that tick wins over expiry

    // status flags: set wins over a write-one clear in the same cycle
    // the reset request is a single registered pulse; the block does not
    // reset itself on it, the system reset must follow, and the
    // reset-cause flag survives until rst or a write-one clear
    // so software can read it until the system reset clears it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            toFlag_r    <= 1'b0;
            warnFlag_r  <= 1'b0;
            causeFlag_r <= 1'b0;
            chipReset_r <= 1'b0;
        end else begin
            chipReset_r <= wdEvent && rstEn_r;                                           // RULE3 RULE7
            if (wdEvent) begin
                toFlag_r <= 1'b1;
            end else if (wrStat && pwdata[`WWD_ST_TIMEOUT]) begin
                toFlag_r <= 1'b0;
            end
            if (warnHit) begin
                warnFlag_r <= 1'b1;                                                      // RULE5
            end else if (wrStat && pwdata[`WWD_ST_WARN]) begin
                warnFlag_r <= 1'b0;
            end
            if (wdEvent && rstEn_r) begin
                causeFlag_r <= 1'b1;                                                     // RULE8
            end else if (wrStat && pwdata[`WWD_ST_RSTCAUSE]) begin
                causeFlag_r <= 1'b0;
            end
        end
    end

    // read data is captured in the setup cycle and held until the next
    // read setup, so the count seen is the one at setup time;
    // unused upper bits read as zero
    // read mux
    wire [31:0] ctrlRd = {25'h0000000, clkSel_r, keepOsc_r, winEn_r, warnEn_r, rstEn_r, enable_r};
    wire [31:0] statRd = {29'h0000000, causeFlag_r, warnFlag_r, toFlag_r};
    wire [31:0] rdMux  = selCtrl  ? ctrlRd :
                         selTo    ? {8'h00, timeout_r} :
                         selCount ? {8'h00, count_r} :
                         selWarn  ? {8'h00, warnVal_r} :
                         selWin   ? {8'h00, window_r} :
                         selStat  ? statRd : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rdMux;
        end
    end

    // pslverr is combinational from the request, valid only in the
    // access phase; the interrupt outputs are levels from flags and
    // stay up until software clears them
    // wdIrq is suppressed when reset action is chosen, since the
    // chip reset makes the interrupt pointless
    assign prdata        = prdata_r;
    assign pready        = 1'b1;
    assign pslverr       = apbAcc && !mapped;
    assign chipResetReq  = chipReset_r;
    assign wdIrq         = toFlag_r && !rstEn_r;                                         // RULE7
    assign warnIrq       = warnFlag_r;
    assign wdoRunInSleep = keepOsc_r;                                                    // RULE11

endmodule
`default_nettype wire

/* common/wwd_defines.svh */
// register offsets, field positions, reset values and feed constants for the windowed watchdog
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

`define WWD_ADDR_W        12
`define WWD_OFF_CTRL      12'h000
`define WWD_OFF_TIMEOUT   12'h004
`define WWD_OFF_FEED      12'h008
`define WWD_OFF_COUNT     12'h00C
`define WWD_OFF_WARN      12'h010
`define WWD_OFF_WINDOW    12'h014
`define WWD_OFF_STATUS    12'h018

`define WWD_CTRL_EN       0
`define WWD_CTRL_RSTEN    1
`define WWD_CTRL_WARNEN   2
`define WWD_CTRL_WINEN    3
`define WWD_CTRL_KEEPOSC  4
`define WWD_CTRL_SEL_LO   5
`define WWD_CTRL_SEL_HI   6

`define WWD_ST_TIMEOUT    0
`define WWD_ST_WARN       1
`define WWD_ST_RSTCAUSE   2

`define WWD_CNT_W         24
`define WWD_TC_MIN        24'h0000FF
`define WWD_TC_RESET      24'h0000FF
`define WWD_WARN_RESET    24'h000000
`define WWD_WIN_RESET     24'hFFFFFF
`define WWD_PRESC_LAST    2'h3
`define WWD_FEED_FIRST    8'hAA
`define WWD_FEED_SECOND   8'h55
`define WWD_SEL_IRC       2'h0
`define WWD_SEL_WDO       2'h1
`define WWD_SEL_MAIN      2'h2

`endif

/* common/wwd_pkg.sv */
// types shared by the windowed watchdog
`default_nettype none
package wwd_pkg;
    typedef enum logic [1:0] {
        FEED_IDLE  = 2'b01,
        FEED_ARMED = 2'b10
    } wwd_feed_t;
endpackage
`default_nettype wire

/* sim/wwd_watchdog_monitor.sv */
// port assertions for the windowed watchdog
`include "wwd_defines.svh"
`default_nettype none
module wwd_watchdog_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ircTick,
    input wire logic        wdoTick,
    input wire logic        chipResetReq,
    input wire logic        wdIrq,
    input wire logic        warnIrq,
    input wire logic        wdoRunInSleep
);
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    // writes to control or status may legally drop the flags
    wire flagWr = wr && (paddr == `WWD_OFF_STATUS || paddr == `WWD_OFF_CTRL);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_ready; pready; endproperty
    property p_slverr; pslverr |-> acc; endproperty
    property p_rdzero; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
    property p_pulse; chipResetReq |=> !chipResetReq; endproperty
    property p_clamp; acc && !pwrite && paddr == `WWD_OFF_TIMEOUT |-> prdata[23:0] >= `WWD_TC_MIN; endproperty
    property p_keep; wr && paddr == `WWD_OFF_CTRL |=> wdoRunInSleep == $past(pwdata[4]); endproperty
    property p_irq; wdIrq && !flagWr |=> wdIrq; endproperty
    property p_warn; warnIrq && !flagWr |=> warnIrq; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_slverr: assert property (p_slverr) else $error("pslverr outside access");
    a_rdzero: assert property (p_rdzero) else $error("unmapped read not zero");
    a_pulse: assert property (p_pulse) else $error("reset request too long");
    a_clamp: assert property (p_clamp) else $error("timeout below minimum");
    a_keep: assert property (p_keep) else $error("sleep keep bit wrong");
    a_irq: assert property (p_irq) else $error("watchdog flag dropped");
    a_warn: assert property (p_warn) else $error("warning flag dropped");
    c_rst: cover property (chipResetReq);
    c_irq: cover property ($rose(wdIrq));
    c_warn: cover property ($rose(warnIrq));
endmodule
bind wwd_watchdog wwd_watchdog_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ircTick(ircTick), .wdoTick(wdoTick), .chipResetReq(chipResetReq), .wdIrq(wdIrq), .warnIrq(warnIrq),
    .wdoRunInSleep(wdoRunInSleep));
`default_nettype wire

/* sim/wwd_watchdog_tb.sv */
// self-checking bench for the windowed watchdog
`include "wwd_defines.svh"
`default_nettype none
module wwd_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        ircTick = 1'b0;
    logic        wdoTick = 1'b0;
    logic [31:0] prdata, rdVal;
    logic        pready, pslverr, chipResetReq, wdIrq, warnIrq, wdoRunInSleep, errVal;
    int          tickCnt = 0, failures = 0, checks_done = 0, waited;
    always #12.5 clk_sys = ~clk_sys;
    // irc ticks every 2nd cycle, wdo every 3rd, so the chosen source shows in elapsed time
    always @(posedge clk_sys) begin
        tickCnt <= tickCnt + 1;
        ircTick <= (tickCnt % 2 == 0);
        wdoTick <= (tickCnt % 3 == 0);
    end
    wwd_watchdog DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ircTick(ircTick),
        .wdoTick(wdoTick), .chipResetReq(chipResetReq), .wdIrq(wdIrq), .warnIrq(warnIrq),
        .wdoRunInSleep(wdoRunInSleep));
    task summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                failures++;
                summarize();
            end
        end while (pready !== 1'b1);
        rdVal = prdata;
        errVal = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h00000000);
        chk(nm, exp, rdVal);
    endtask
    // 0 reset request, 1 watchdog flag, 2 warning flag
    task waitfor(input int which, input int lim);
        waited = 0;
        while ((which == 0 ? chipResetReq : which == 1 ? wdIrq : warnIrq) !== 1'b1) begin
            @(posedge clk_sys);
            waited++;
            if (waited > lim) begin
                $display("CHECK FAILED wait %0d expected 1 seen 0", which);
                failures++;
                summarize();
            end
        end
    endtask
    task do_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
    endtask
    task t_regs;
        rdchk(`WWD_OFF_CTRL, 32'h00000000, "ctrl");
        rdchk(`WWD_OFF_WARN, 32'h00000000, "warn");
        rdchk(`WWD_OFF_WINDOW, 32'h00FFFFFF, "window");
        rdchk(`WWD_OFF_STATUS, 32'h00000000, "status");
        apb(1'b0, 12'h01C, 32'h00000000);
        chk("unmapped err", 32'h00000001, {31'h0, errVal});
        apb(1'b1, `WWD_OFF_TIMEOUT, 32'h00000010);
        rdchk(`WWD_OFF_TIMEOUT, 32'h000000FF, "timeout clamp");
        apb(1'b1, `WWD_OFF_COUNT, 32'h00000005);
        rdchk(`WWD_OFF_COUNT, 32'h000000FF, "count ro");
        $display("test regs done");
    endtask
    task t_expire;
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000003);
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000002);
        rdchk(`WWD_OFF_CTRL, 32'h00000003, "ctrl sticky");
        waitfor(0, 3000);
        chk("expiry time", 32'h00000001, {31'h0, waited > 1950 && waited < 2100});
        rdchk(`WWD_OFF_STATUS, 32'h00000005, "reset cause");
        rdchk(`WWD_OFF_CTRL, 32'h00000002, "ctrl after event");
        do_reset();
        rdchk(`WWD_OFF_STATUS, 32'h00000000, "cause cleared");
        $display("test expire done");
    endtask
    task t_feed;
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000001);
        repeat (4) begin
            repeat (600) @(posedge clk_sys);
            apb(1'b1, `WWD_OFF_FEED, 32'h000000AA);
            apb(1'b1, `WWD_OFF_FEED, 32'h00000055);
        end
        chk("fed no irq", 32'h00000000, {31'h0, wdIrq});
        apb(1'b1, `WWD_OFF_FEED, 32'h000000AA);
        apb(1'b0, `WWD_OFF_CTRL, 32'h00000000);
        waitfor(1, 10);
        rdchk(`WWD_OFF_STATUS, 32'h00000001, "bad feed");
        apb(1'b1, `WWD_OFF_STATUS, 32'h00000001);
        rdchk(`WWD_OFF_STATUS, 32'h00000000, "flag clear");
        $display("test feed done");
    endtask
    task t_window;
        do_reset();
        apb(1'b1, `WWD_OFF_WINDOW, 32'h00000080);
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000009);
        apb(1'b1, `WWD_OFF_FEED, 32'h000000AA);
        apb(1'b1, `WWD_OFF_FEED, 32'h00000055);
        waitfor(1, 10);
        rdchk(`WWD_OFF_STATUS, 32'h00000001, "early feed");
        $display("test window done");
    endtask
    task t_warn;
        do_reset();
        apb(1'b1, `WWD_OFF_WARN, 32'h000000F0);
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000035);
        @(posedge clk_sys);
        chk("keep osc", 32'h00000001, {31'h0, wdoRunInSleep});
        waitfor(2, 400);
        chk("wdo rate", 32'h00000001, {31'h0, waited > 150});
        rdchk(`WWD_OFF_STATUS, 32'h00000002, "warning");
        $display("test warn done");
    endtask
    // main clock selected in the windowed variant must count at the rc rate
    task t_sel;
        do_reset();
        apb(1'b1, `WWD_OFF_WARN, 32'h000000F0);
        apb(1'b1, `WWD_OFF_CTRL, 32'h00000045);
        waitfor(2, 400);
        chk("main refused", 32'h00000001, {31'h0, waited > 100});
        $display("test sel done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_expire();
        t_feed();
        t_window();
        t_warn();
        t_sel();
        summarize();
    end
endmodule
`default_nettype wire
